// *** rtl/progport_pkg.sv ***
package progport_pkg;

    // pin sample vector: {data[7:0], sel_hi, sel_lo, bs1, bs2, load, wr_n, oe_n}
    localparam int PIN_W    = 15;
    localparam int P_OE     = 0;
    localparam int P_WR     = 1;
    localparam int P_LOAD   = 2;
    localparam int P_BS2    = 3;
    localparam int P_BS1    = 4;
    localparam int P_XLO    = 5;
    localparam int P_XHI    = 6;
    localparam int P_DATA   = 7;

    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;

    localparam logic [7:0] CMD_NOP       = 8'h00;
    localparam logic [7:0] CMD_WR_FUSE   = 8'h40;
    localparam logic [7:0] CMD_WR_FLASH  = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_FUSE   = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH  = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

    localparam logic [7:0] FUSE_LO_RST  = 8'hff;
    localparam logic [7:0] FUSE_HI_RST  = 8'hff;
    localparam logic [7:0] FUSE_EXT_RST = 8'hff;

    localparam int FLASH_AW   = 12;
    localparam int EE_AW      = 9;
    localparam int PAGE_WB    = 5;
    localparam int FIFO_DEPTH = 16;

    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS  = 3700000;
    localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] FSEL_LO  = 2'h0;
    localparam logic [1:0] FSEL_HI  = 2'h1;
    localparam logic [1:0] FSEL_EXT = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_DRAIN = 3'h2,
        ST_BUSY  = 3'h4
    } state_e;

    // fuse byte picked by the two byte-select lines, same for write and read
    function automatic logic [1:0] fuse_sel(input logic bs1, input logic bs2);
        fuse_sel = bs2 ? FSEL_EXT : (bs1 ? FSEL_HI : FSEL_LO);
    endfunction

endpackage

// *** rtl/word_fifo.sv ***
`timescale 1ns/1ps
module word_fifo #(
    parameter int W     = 21,
    parameter int DEPTH = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic         clear,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr_ptr;
        logic [AW-1:0]           rd_ptr;
        logic [AW:0]             count;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  push;
    logic  pop;

    assign in_ready  = (q.count != FULL);
    assign out_valid = (q.count != '0);
    assign out_data  = q.mem[q.rd_ptr];

    always_comb begin
        d    = q;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push) begin
            d.mem[q.wr_ptr] = in_data;
            d.wr_ptr        = (q.wr_ptr == LAST) ? '0 : q.wr_ptr + 1'b1;
        end
        if (pop) begin
            d.rd_ptr = (q.rd_ptr == LAST) ? '0 : q.rd_ptr + 1'b1;
        end
        d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
        // a flush drops anything pushed in the same cycle
        if (clear) begin
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.count  = '0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

// *** rtl/nv_array.sv ***
`timescale 1ns/1ps
module nv_array #(
    parameter int W  = 16,
    parameter int AW = 12
) (
    input  wire logic          sys_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [W-1:0]       rdata
);
    // no reset: contents model nonvolatile cells
    logic [W-1:0] cells [2**AW];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
        rdata <= cells[raddr];
    end

endmodule

// *** rtl/parallel_program_port.sv ***
`timescale 1ns/1ps
module parallel_program_port #(
    parameter int PROG_CYCLES = progport_pkg::PROG_CYCLES,
    parameter int FLASH_AW    = progport_pkg::FLASH_AW,
    parameter int EE_AW       = progport_pkg::EE_AW,
    parameter int PAGE_WB     = progport_pkg::PAGE_WB,
    parameter int FIFO_DEPTH  = progport_pkg::FIFO_DEPTH
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe,
    input  wire logic       action_select_hi,
    input  wire logic       action_select_lo,
    input  wire logic       byte_select_one,
    input  wire logic       byte_select_two,
    input  wire logic       load_strobe,
    input  wire logic       write_strobe_n,
    input  wire logic       output_enable_n,
    output logic            ready_busy
);
    localparam int CW = $clog2(PROG_CYCLES + 1);
    localparam int FW = PAGE_WB + 16;
    localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES);

    typedef struct packed {
        logic [progport_pkg::PIN_W-1:0] sync1;
        logic [progport_pkg::PIN_W-1:0] sync2;
        logic                           load_prev;
        logic                           wr_prev;
        progport_pkg::state_e           state;
        logic [7:0]                     cmd;
        logic [7:0]                     addr_hi;
        logic [7:0]                     addr_lo;
        logic [7:0]                     data_lo;
        logic [7:0]                     data_hi;
        logic                           push_pend;
        logic [7:0]                     fuse_lo;
        logic [7:0]                     fuse_hi;
        logic [7:0]                     fuse_ext;
        logic [CW-1:0]                  busy_cnt;
        logic [7:0]                     dout;
        logic                           doe;
    } port_s;

    port_s           q;
    port_s           d;
    logic            load_rise;
    logic            wr_fall;
    logic            oe_act;
    logic [1:0]      act;
    logic            bs1;
    logic [1:0]      fsel;
    logic [7:0]      pin_data;
    logic [15:0]     full_addr;
    logic            fifo_clear;
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic            fifo_out_ready;
    logic [FW-1:0]   fifo_in_data;
    logic [FW-1:0]   fifo_out_data;
    logic            flash_we;
    logic [FLASH_AW-1:0] flash_waddr;
    logic [15:0]     flash_rdata;
    logic            ee_we;
    logic [7:0]      ee_rdata;

    // edge detectors read only the second synchroniser stage
    assign load_rise = q.sync2[progport_pkg::P_LOAD] && !q.load_prev;
    assign wr_fall   = !q.sync2[progport_pkg::P_WR] && q.wr_prev;
    assign oe_act    = !q.sync2[progport_pkg::P_OE];
    assign act       = {q.sync2[progport_pkg::P_XHI], q.sync2[progport_pkg::P_XLO]};
    assign bs1       = q.sync2[progport_pkg::P_BS1];
    assign fsel      = progport_pkg::fuse_sel(bs1, q.sync2[progport_pkg::P_BS2]);
    assign pin_data  = q.sync2[progport_pkg::P_DATA +: 8];
    assign full_addr = {q.addr_hi, q.addr_lo};

    assign fifo_in_data = {q.addr_lo[PAGE_WB-1:0], q.data_hi, q.data_lo};
    assign flash_waddr  = {full_addr[FLASH_AW-1:PAGE_WB], fifo_out_data[FW-1 -: PAGE_WB]};

    assign data_out   = q.dout;
    assign data_oe    = q.doe;
    assign ready_busy = (q.state == progport_pkg::ST_IDLE);

    always_comb begin
        d              = q;
        fifo_clear     = 1'b0;
        fifo_out_ready = 1'b0;
        flash_we       = 1'b0;
        ee_we          = 1'b0;
        d.sync1        = {data_in, action_select_hi, action_select_lo, byte_select_one,
                          byte_select_two, load_strobe, write_strobe_n, output_enable_n};
        d.sync2        = q.sync1;
        d.load_prev    = q.sync2[progport_pkg::P_LOAD];
        d.wr_prev      = q.sync2[progport_pkg::P_WR];
        // a full buffer holds the word back until space frees up
        if (q.push_pend && fifo_in_ready) begin
            d.push_pend = 1'b0;
        end
        unique case (q.state)
            progport_pkg::ST_IDLE: begin
                if (load_rise) begin
                    case (act)
                        progport_pkg::ACT_ADDR: begin
                            if (bs1) begin
                                d.addr_hi = pin_data;
                            end else begin
                                d.addr_lo = pin_data;
                            end
                        end
                        progport_pkg::ACT_DATA: begin
                            if (bs1) begin
                                d.data_hi   = pin_data;
                                d.push_pend = 1'b1;
                            end else begin
                                d.data_lo = pin_data;
                            end
                        end
                        progport_pkg::ACT_CMD: begin
                            d.cmd = pin_data;
                            if (pin_data == progport_pkg::CMD_NOP) begin
                                fifo_clear  = 1'b1;
                                d.push_pend = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (wr_fall) begin
                    case (q.cmd)
                        progport_pkg::CMD_WR_FLASH: begin
                            d.state = progport_pkg::ST_DRAIN;
                        end
                        progport_pkg::CMD_WR_FUSE: begin
                            // stored as given: 0 is programmed, 1 is erased
                            unique case (fsel)
                                progport_pkg::FSEL_HI:  d.fuse_hi  = q.data_lo;
                                progport_pkg::FSEL_EXT: d.fuse_ext = q.data_lo;
                                default:                d.fuse_lo  = q.data_lo;
                            endcase
                            d.state    = progport_pkg::ST_BUSY;
                            d.busy_cnt = PROG_LOAD;
                        end
                        progport_pkg::CMD_WR_EEPROM: begin
                            ee_we      = 1'b1;
                            d.state    = progport_pkg::ST_BUSY;
                            d.busy_cnt = PROG_LOAD;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            progport_pkg::ST_DRAIN: begin
                fifo_out_ready = 1'b1;
                flash_we       = fifo_out_valid;
                if (!fifo_out_valid && !q.push_pend) begin
                    d.state    = progport_pkg::ST_BUSY;
                    d.busy_cnt = PROG_LOAD;
                end
            end
            progport_pkg::ST_BUSY: begin
                d.busy_cnt = q.busy_cnt - 1'b1;
                if (q.busy_cnt == CW'(1)) begin
                    d.state = progport_pkg::ST_IDLE;
                end
            end
        endcase
        // read path: drive only while enabled and idle
        d.doe = 1'b0;
        if (oe_act && q.state == progport_pkg::ST_IDLE) begin
            case (q.cmd)
                progport_pkg::CMD_RD_EEPROM: begin
                    d.doe  = !bs1;
                    d.dout = ee_rdata;
                end
                progport_pkg::CMD_RD_FLASH: begin
                    d.doe  = 1'b1;
                    d.dout = bs1 ? flash_rdata[15:8] : flash_rdata[7:0];
                end
                progport_pkg::CMD_RD_FUSE: begin
                    d.doe = 1'b1;
                    unique case (fsel)
                        progport_pkg::FSEL_HI:  d.dout = q.fuse_hi;
                        progport_pkg::FSEL_EXT: d.dout = q.fuse_ext;
                        default:                d.dout = q.fuse_lo;
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q          <= '0;
            q.sync1    <= '1;
            q.sync2    <= '1;
            // matches the synchroniser's reset ones, so no false load rise at release
            q.load_prev <= 1'b1;
            q.wr_prev  <= 1'b1;
            q.state    <= progport_pkg::ST_IDLE;
            q.fuse_lo  <= progport_pkg::FUSE_LO_RST;
            q.fuse_hi  <= progport_pkg::FUSE_HI_RST;
            q.fuse_ext <= progport_pkg::FUSE_EXT_RST;
        end else begin
            q <= d;
        end
    end

    word_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_page_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clear     (fifo_clear),
        .in_valid  (q.push_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    nv_array #(
        .W  (16),
        .AW (FLASH_AW)
    ) u_flash (
        .sys_clk (sys_clk),
        .we      (flash_we),
        .waddr   (flash_waddr),
        .wdata   (fifo_out_data[15:0]),
        .raddr   (full_addr[FLASH_AW-1:0]),
        .rdata   (flash_rdata)
    );

    nv_array #(
        .W  (8),
        .AW (EE_AW)
    ) u_eeprom (
        .sys_clk (sys_clk),
        .we      (ee_we),
        .waddr   (full_addr[EE_AW-1:0]),
        .wdata   (q.data_lo),
        .raddr   (full_addr[EE_AW-1:0]),
        .rdata   (ee_rdata)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    logic idle;
    assign idle = (q.state == progport_pkg::ST_IDLE);

    a_load_low_data: assert property (
        idle && load_rise && act == progport_pkg::ACT_DATA && !bs1
        |=> q.data_lo == $past(pin_data))
        else $error("low data byte not latched");
    a_load_high_data: assert property (
        idle && load_rise && act == progport_pkg::ACT_DATA && bs1
        |=> q.data_hi == $past(pin_data) && q.push_pend)
        else $error("high data byte not latched");
    a_load_addr_hi: assert property (
        idle && load_rise && act == progport_pkg::ACT_ADDR && bs1
        |=> q.addr_hi == $past(pin_data))
        else $error("high address not latched");
    a_page_write_busy: assert property (
        idle && !load_rise && wr_fall && q.cmd == progport_pkg::CMD_WR_FLASH
        |=> !ready_busy)
        else $error("ready not low after page write pulse");
    a_nop_flush: assert property (
        idle && load_rise && act == progport_pkg::ACT_CMD && pin_data == '0
        |=> !fifo_out_valid && !q.push_pend)
        else $error("no-op did not clear write state");
    a_page_addr: assert property (
        flash_we |-> flash_waddr[PAGE_WB-1:0] == fifo_out_data[FW-1 -: PAGE_WB])
        else $error("word index not taken from buffered low address");
    a_eeprom_read: assert property (
        idle && oe_act && !bs1 && q.cmd == progport_pkg::CMD_RD_EEPROM
        |=> data_oe && data_out == $past(ee_rdata))
        else $error("eeprom byte not driven");
    a_fuse_low: assert property (
        idle && !load_rise && wr_fall && q.cmd == progport_pkg::CMD_WR_FUSE
        && fsel == progport_pkg::FSEL_LO
        |=> q.fuse_lo == $past(q.data_lo) && !ready_busy)
        else $error("fuse low byte not written");
    a_busy_hold: assert property (
        q.state == progport_pkg::ST_BUSY && q.busy_cnt > CW'(1)
        |=> !ready_busy && q.busy_cnt == $past(q.busy_cnt) - 1'b1)
        else $error("ready rose before program time ended");
    a_busy_end: assert property (
        q.state == progport_pkg::ST_BUSY && q.busy_cnt == CW'(1) |=> ready_busy)
        else $error("ready did not return after program time");

    c_page_write: cover property (q.state == progport_pkg::ST_DRAIN && flash_we);
    c_fifo_stall: cover property (q.push_pend && !fifo_in_ready);
    c_fuse_ext:   cover property (wr_fall && idle && fsel == progport_pkg::FSEL_EXT
                                  && q.cmd == progport_pkg::CMD_WR_FUSE);
    c_ee_read:    cover property (data_oe && q.cmd == progport_pkg::CMD_RD_EEPROM);

endmodule

// *** verification/prog_model.sv ***
`timescale 1ns/1ps
module prog_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       ready_busy,
    output logic [7:0]      data_in,
    output logic            action_select_hi,
    output logic            action_select_lo,
    output logic            byte_select_one,
    output logic            byte_select_two,
    output logic            load_strobe,
    output logic            write_strobe_n,
    output logic            output_enable_n
);
    // pins are synchronised in the device, so every phase is held for at least four clocks
    localparam int HOLD = 4;

    initial begin
        data_in = 8'h00;
        {action_select_hi, action_select_lo} = 2'h3;
        {byte_select_one, byte_select_two} = 2'h0;
        load_strobe = 1'b0;
        write_strobe_n = 1'b1;
        output_enable_n = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
        @(posedge sys_clk);
        {action_select_hi, action_select_lo} <= act;
        byte_select_one <= bs1;
        data_in <= val;
        tick(HOLD);
        load_strobe <= 1'b1;
        tick(HOLD);
        load_strobe <= 1'b0;
        tick(HOLD);
        {action_select_hi, action_select_lo} <= 2'h3;
        // released bus must not keep showing the old byte
        data_in <= ~val;
    endtask

    task automatic set_bs(input logic bs1, input logic bs2);
        @(posedge sys_clk);
        byte_select_one <= bs1;
        byte_select_two <= bs2;
        tick(HOLD);
    endtask

    // busy returns the number of cycles ready_busy was seen low
    task automatic write_pulse(output int busy);
        busy = 0;
        @(posedge sys_clk);
        write_strobe_n <= 1'b0;
        repeat (8) begin
            @(negedge sys_clk);
            busy += int'(ready_busy === 1'b0);
        end
        @(posedge sys_clk);
        write_strobe_n <= 1'b1;
        while (busy > 0 && busy < 4000) begin
            @(negedge sys_clk);
            if (ready_busy !== 1'b0) break;
            busy++;
        end
    endtask

    task automatic read(input logic bs1, input logic bs2, output logic oe, output logic [7:0] v);
        @(posedge sys_clk);
        byte_select_one <= bs1;
        byte_select_two <= bs2;
        output_enable_n <= 1'b0;
        tick(5);
        @(negedge sys_clk);
        oe = data_oe;
        v = data_out;
        @(posedge sys_clk);
        output_enable_n <= 1'b1;
        byte_select_one <= 1'b0;
        byte_select_two <= 1'b0;
        tick(5);
    endtask
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
    localparam int PROG = 20;
    localparam int NW   = 16;

    logic       sys_clk;
    logic       reset;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic       data_oe;
    logic       xhi;
    logic       xlo;
    logic       bs1;
    logic       bs2;
    logic       load_strobe;
    logic       wr_n;
    logic       oe_n;
    logic       ready_busy;
    int         errors;
    int         cmp_count;
    int         busy;
    logic       oe;
    logic [7:0] v;
    logic [7:0] fv [3];

    always #2.5 sys_clk = ~sys_clk;

    parallel_program_port #(.PROG_CYCLES(PROG)) dut_u (
        .sys_clk         (sys_clk),
        .reset           (reset),
        .data_in         (data_in),
        .data_out        (data_out),
        .data_oe         (data_oe),
        .action_select_hi(xhi),
        .action_select_lo(xlo),
        .byte_select_one (bs1),
        .byte_select_two (bs2),
        .load_strobe     (load_strobe),
        .write_strobe_n  (wr_n),
        .output_enable_n (oe_n),
        .ready_busy      (ready_busy)
    );

    prog_model prog_u (
        .sys_clk         (sys_clk),
        .data_out        (data_out),
        .data_oe         (data_oe),
        .ready_busy      (ready_busy),
        .data_in         (data_in),
        .action_select_hi(xhi),
        .action_select_lo(xlo),
        .byte_select_one (bs1),
        .byte_select_two (bs2),
        .load_strobe     (load_strobe),
        .write_strobe_n  (wr_n),
        .output_enable_n (oe_n)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] c);
        prog_u.load(progport_pkg::ACT_CMD, 1'b0, c);
    endtask

    task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
        prog_u.load(progport_pkg::ACT_ADDR, 1'b1, hi);
        prog_u.load(progport_pkg::ACT_ADDR, 1'b0, lo);
    endtask

    task automatic busy_in(input int lo, input int hi);
        check(16'(busy >= lo && busy <= hi), 16'h0001);
    endtask

    initial begin
        #(20000 * 5);
        errors++;
        give_verdict();
    end

    initial begin
        sys_clk = 1'b0;
        reset = 1'b1;
        errors = 0;
        cmp_count = 0;
        fv = '{8'h5a, 8'ha6, 8'h3c};
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check({15'h0, ready_busy}, 16'h0001);
        check({15'h0, data_oe}, 16'h0000);
        // flash page: sixteen words fill the buffer, page bit in the low address byte
        cmd(progport_pkg::CMD_WR_FLASH);
        for (int w = 0; w < NW; w++) begin
            prog_u.load(progport_pkg::ACT_ADDR, 1'b0, 8'h20 + 8'(w));
            prog_u.load(progport_pkg::ACT_DATA, 1'b0, 8'(w * 7 + 3));
            prog_u.load(progport_pkg::ACT_DATA, 1'b1, ~8'(w * 7 + 3));
        end
        prog_u.load(progport_pkg::ACT_ADDR, 1'b1, 8'h01);
        prog_u.write_pulse(busy);
        busy_in(PROG - 1, PROG + NW + 2);
        // a stray word queued before the no-op must never reach the array
        prog_u.load(progport_pkg::ACT_ADDR, 1'b0, 8'h20);
        prog_u.load(progport_pkg::ACT_DATA, 1'b0, 8'hee);
        prog_u.load(progport_pkg::ACT_DATA, 1'b1, 8'hee);
        cmd(progport_pkg::CMD_NOP);
        prog_u.write_pulse(busy);
        check(16'(busy), 16'h0000);
        cmd(progport_pkg::CMD_WR_FLASH);
        prog_u.write_pulse(busy);
        busy_in(PROG, PROG + 2);
        cmd(progport_pkg::CMD_RD_FLASH);
        prog_u.load(progport_pkg::ACT_ADDR, 1'b1, 8'h01);
        for (int w = 0; w < NW; w++) begin
            prog_u.load(progport_pkg::ACT_ADDR, 1'b0, 8'h20 + 8'(w));
            prog_u.read(1'b0, 1'b0, oe, v);
            check({7'h0, oe, v}, {8'h01, 8'(w * 7 + 3)});
            prog_u.read(1'b1, 1'b0, oe, v);
            check({7'h0, oe, v}, {8'h01, ~8'(w * 7 + 3)});
        end
        // eeprom byte written, then read back; high byte select refuses the drive
        cmd(progport_pkg::CMD_WR_EEPROM);
        prog_u.load(progport_pkg::ACT_DATA, 1'b0, 8'h6b);
        addr(8'h01, 8'h2c);
        prog_u.write_pulse(busy);
        busy_in(PROG - 1, PROG + 1);
        cmd(progport_pkg::CMD_RD_EEPROM);
        addr(8'h01, 8'h2c);
        prog_u.read(1'b0, 1'b0, oe, v);
        check({7'h0, oe, v}, 16'h016b);
        check({15'h0, data_oe}, 16'h0000);
        prog_u.read(1'b1, 1'b0, oe, v);
        check({15'h0, oe}, 16'h0000);
        // low, high and extended fuse bytes, each from the low data byte
        for (int i = 0; i < 3; i++) begin
            cmd(progport_pkg::CMD_WR_FUSE);
            prog_u.load(progport_pkg::ACT_DATA, 1'b0, fv[i]);
            prog_u.set_bs(i == 1, i == 2);
            prog_u.write_pulse(busy);
            busy_in(PROG - 1, PROG + 1);
            prog_u.set_bs(1'b0, 1'b0);
        end
        cmd(progport_pkg::CMD_RD_FUSE);
        for (int i = 0; i < 3; i++) begin
            prog_u.read(i == 1, i == 2, oe, v);
            check({7'h0, oe, v}, {8'h01, fv[i]});
        end
        give_verdict();
    end
endmodule
